// ### testbench/lpd_loop_model.sv
// Squared loop oscillator model for both channels.
// Assumes the bench sets each period in clock cycles; zero stops that loop.
`default_nettype none
module lpd_loop_model (
    input  wire logic             i_clk,
    input  wire logic [1:0]       i_osc_en,
    input  wire logic [1:0][15:0] i_period,
    output wire logic [1:0]       o_loop_sq
);
    logic [1:0][15:0] cnt_r = '0;
    logic [1:0]       sq_r  = 2'h0;
    // Comparator rests low while its oscillator is switched off
    always @(posedge i_clk) begin
        for (int c = 0; c < 2; c++) begin
            if (!i_osc_en[c] || i_period[c] == 16'h0) begin
                cnt_r[c] <= 16'h0;
                sq_r[c]  <= 1'b0;
            end else begin
                cnt_r[c] <= (cnt_r[c] + 16'h1 >= i_period[c]) ? 16'h0 : cnt_r[c] + 16'h1;
                sq_r[c]  <= cnt_r[c] < (i_period[c] >> 1);
            end
        end
    end
    assign o_loop_sq = sq_r;
endmodule : lpd_loop_model
`default_nettype wire

// ### testbench/lpd_top_bench.sv
// Self-checking bench for the loop detector channel logic.
// Assumes lpd_top, the loop model and the bound port checker.
`default_nettype none
`include "lpd_params.svh"
module lpd_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import lpd_pkg::*;
    localparam int         TICK = 5;
    localparam int         LAMP = 1000 * TICK;
    localparam logic [15:0] NOM = 16'h96;
    logic             clk, rst, ext_reset_n, sw_strobe, test_mode;
    logic [1:0]       loop_sq, call, osc_en, lamp_red, lamp_green, call_seen;
    lpd_chsw_t [1:0]  ch_sw;
    lpd_board_t       board_sw;
    logic [1:0][15:0] period;
    logic [1:0]       exp_q [$];
    int               errors, samples_checked;

    lpd_top #(.P_TICK_CYC(TICK), .P_TIMEOUT_CYC(4000)) dut_u (
        .i_clk(clk), .i_rst(rst), .i_loop_sq(loop_sq), .i_ch_sw(ch_sw), .i_board_sw(board_sw),
        .i_ext_reset_n(ext_reset_n), .o_call(call), .o_osc_en(osc_en), .o_sw_strobe(sw_strobe),
        .o_lamp_red(lamp_red), .o_lamp_green(lamp_green), .o_test_mode(test_mode));
    lpd_loop_model loop_u (.i_clk(clk), .i_osc_en(osc_en), .i_period(period), .o_loop_sq(loop_sq));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================================
    // Reporting and comparison
    task automatic final_report();
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic give_up();
        errors++;
        final_report();
    endtask : give_up
    task automatic check_call(input logic [1:0] exp, input logic [1:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch o_call expected %0h seen %0h", exp, got);
        end
    endtask : check_call
    task automatic check_lamp(input string what, input int exp, input int got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_lamp
    // ==========================================================
    // Bounded waits and lamp sampling over one whole pattern period
    task automatic wait_call(input logic [1:0] v);
        int t;
        exp_q.push_back(v);
        for (t = 0; t < 20000 && call !== v; t++) @(posedge clk);
        if (call !== v) give_up();
        #5;
    endtask : wait_call
    task automatic wait_scans(input int n);
        int k = 0;
        logic [1:0] prev = osc_en;
        for (int t = 0; t < 5000 * n && k < n; t++) begin
            @(posedge clk);
            if ((osc_en & ~prev) != 2'h0) k++;
            prev = osc_en;
        end
        if (k < n) give_up();
        #5;
    endtask : wait_scans
    task automatic lamp_window(input int r0, input int g0, input int r1, input int g1);
        int cr[2] = '{0, 0}, cg[2] = '{0, 0};
        repeat (LAMP) begin
            @(negedge clk);
            for (int c = 0; c < 2; c++) begin
                if (lamp_red[c] === 1'b1) cr[c]++;
                if (lamp_green[c] === 1'b1) cg[c]++;
            end
        end
        check_lamp("red0", r0, cr[0]);
        check_lamp("green0", g0, cg[0]);
        check_lamp("red1", r1, cr[1]);
        check_lamp("green1", g1, cg[1]);
        @(posedge clk) #5;
    endtask : lamp_window
    // Any call change is a result; it must match the oldest note
    always @(negedge clk) begin
        if (!rst && call !== call_seen) begin
            check_call(exp_q.size() != 0 ? exp_q.pop_front() : call_seen, call);
            call_seen <= call;
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        ext_reset_n = 1'b1;
        ch_sw = {`LPD_CHSW_RST, `LPD_CHSW_RST};
        board_sw = 2'h0;
        period = {NOM, NOM};
        call_seen = 2'h0;
        errors = 0;
        samples_checked = 0;
        void'($urandom(69538));
        repeat (16) @(posedge clk);
        #5 rst = 1'b0;
        ch_sw[0].sens = 3'h0;
        lamp_window(0, 0, 0, 0);
        // Sixteen counts lower stays under the level 0 threshold
        period[0] = NOM - 16'h1;
        wait_scans(3);
        period[0] = NOM - 16'h3;
        wait_call(2'h1);
        period[1] = 16'h3c + 16'($urandom % 30);
        wait_call(2'h3);
        lamp_window(0, LAMP, LAMP / 2, 0);
        period[0] = NOM;
        wait_call(2'h2);
        period[1] = NOM;
        wait_call(2'h0);
        lamp_window(0, 0, 150 * TICK, 0);
        period[1] = NOM - 16'h2 - 16'($urandom % 3);
        wait_call(2'h2);
        period[0] = 16'h0;
        wait_call(2'h3);
        ch_sw[0].fail_safe = 1'b0;
        wait_call(2'h2);
        wait_scans(3);
        lamp_window(LAMP, 0, 150 * TICK, 750 * TICK);
        ext_reset_n = 1'b0;
        wait_call(2'h0);
        repeat (600) @(posedge clk);
        #5 ext_reset_n = 1'b1;
        wait_scans(3);
        lamp_window(LAMP, 0, 0, 0);
        board_sw.test = 1'b1;
        repeat (8) @(posedge clk);
        lamp_window(LAMP / 2, LAMP / 2, LAMP / 2, LAMP / 2);
        board_sw.test = 1'b0;
        ch_sw[1].dis = 1'b1;
        repeat (100) @(posedge clk);
        check_lamp("pending calls", 0, exp_q.size());
        final_report();
    end
endmodule : lpd_top_bench
`default_nettype wire

// ### testbench/lpd_top_properties.sv
// Port-level checks for the loop detector channel logic.
// Assumes it is bound to lpd_top and sees only that module's ports.
`default_nettype none
module lpd_top_properties #(
    parameter int P_TICK_CYC = 20
) (
    input wire logic                     i_clk,
    input wire logic                     i_rst,
    input wire logic [1:0]               i_loop_sq,
    input wire lpd_pkg::lpd_chsw_t [1:0] i_ch_sw,
    input wire lpd_pkg::lpd_board_t      i_board_sw,
    input wire logic                     i_ext_reset_n,
    input wire logic [1:0]               o_call,
    input wire logic [1:0]               o_osc_en,
    input wire logic                     o_sw_strobe,
    input wire logic [1:0]               o_lamp_red,
    input wire logic [1:0]               o_lamp_green,
    input wire logic                     o_test_mode
);
    import lpd_pkg::*;
    // ==========================================================
    // Cycles channel 1 has been held disabled; saturates
    logic [15:0] dis_cnt_r;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dis_cnt_r <= 16'h0;
        end else if (!i_ch_sw[1].dis) begin
            dis_cnt_r <= 16'h0;
        end else if (dis_cnt_r != 16'hffff) begin
            dis_cnt_r <= dis_cnt_r + 16'h1;
        end
    end
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ==========================================================
    // Assertions
    a_osc_alternate: assert property (o_osc_en != 2'h3)
        else $error("both oscillators enabled");
    a_strobe_pulse: assert property (o_sw_strobe |=> !o_sw_strobe)
        else $error("switch strobe longer than one cycle");
    a_strobe_period: assert property (o_sw_strobe |-> ##P_TICK_CYC o_sw_strobe)
        else $error("switch strobe off its tick spacing");
    a_ext_call_clear: assert property (!i_ext_reset_n [*3] |-> o_call == 2'h0)
        else $error("call held during external reset");
    a_ext_lamp_dark: assert property (!i_ext_reset_n [*5] ##0 !o_test_mode |-> (o_lamp_red | o_lamp_green) == 2'h0)
        else $error("lamp lit during external reset");
    a_lamp_one_colour: assert property ((o_lamp_red & o_lamp_green) == 2'h0)
        else $error("lamp red and green together");
    a_test_off: assert property (o_sw_strobe && !i_board_sw.test ##1 !i_board_sw.test |=> ##1 !o_test_mode)
        else $error("test mode with its switch off");
    a_dis_quiet: assert property (dis_cnt_r >= 16'h20 |-> !o_call[1] && !o_lamp_red[1])
        else $error("disabled channel not quiet");
endmodule : lpd_top_properties

bind lpd_top lpd_top_properties #(.P_TICK_CYC(P_TICK_CYC)) chk_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_loop_sq(i_loop_sq), .i_ch_sw(i_ch_sw), .i_board_sw(i_board_sw),
    .i_ext_reset_n(i_ext_reset_n), .o_call(o_call), .o_osc_en(o_osc_en), .o_sw_strobe(o_sw_strobe),
    .o_lamp_red(o_lamp_red), .o_lamp_green(o_lamp_green), .o_test_mode(o_test_mode));
`default_nettype wire

// ### verilog/lpd_lamp.sv
// Status lamp pattern for one channel.
// Assumes a shared 0..999 ms phase from the top and registered inputs.
`default_nettype none
`include "lpd_params.svh"
module lpd_lamp (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic [9:0]        i_phase,
    input  wire logic              i_det,
    input  wire lpd_pkg::lpd_fail_t i_fail,
    input  wire logic              i_prior,
    input  wire logic              i_test,
    output var  logic              o_red,
    output var  logic              o_green
);
    import lpd_pkg::*;

    logic red_nxt;
    logic green_nxt;
    logic three;

    // ==========================================================
    // Pattern select
    always_comb begin
        three = (i_phase < `LPD_FLASH_MS)
             || (i_phase >= `LPD_FLASH_GAP_MS && i_phase < (`LPD_FLASH_GAP_MS + `LPD_FLASH_MS))
             || (i_phase >= (`LPD_FLASH_GAP_MS << 1) && i_phase < ((`LPD_FLASH_GAP_MS << 1) + `LPD_FLASH_MS));
        red_nxt   = 1'b0;
        green_nxt = 1'b0;
        if (i_test) begin
            // Walks both colours so an operator can see each lamp die
            red_nxt   = (i_phase < `LPD_HALF_MS);
            green_nxt = (i_phase >= `LPD_HALF_MS);
        end else if (i_fail == lpd_fail_open) begin
            red_nxt = 1'b1;
        end else if (i_fail == lpd_fail_short) begin
            red_nxt = (i_phase < `LPD_HALF_MS);
        end else if (i_det && i_prior) begin
            red_nxt   = three;
            green_nxt = (i_phase >= (`LPD_LAMP_PER_MS - `LPD_GREEN_MS));
        end else if (i_prior) begin
            red_nxt = three;
        end else if (i_det) begin
            green_nxt = 1'b1;
        end
        // All else stays dark
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_red   <= 1'b0;
            o_green <= 1'b0;
        end else begin
            o_red   <= red_nxt;
            o_green <= green_nxt;
        end
    end
endmodule : lpd_lamp
`default_nettype wire

// ### verilog/lpd_params.svh
// Constants for the two-channel loop detector channel logic.
// Assumes a 20 MHz system clock; all times are kept in their own unit.
`ifndef LPD_PARAMS_SVH
`define LPD_PARAMS_SVH
// ==========================================================
// Clock and derived cycle counts
`define LPD_CLK_NS       50
`define LPD_TICK_NS      1000000
`define LPD_TIMEOUT_NS   2000000
`define LPD_TICK_CYC     (`LPD_TICK_NS / `LPD_CLK_NS)
`define LPD_TIMEOUT_CYC  (`LPD_TIMEOUT_NS / `LPD_CLK_NS)
`define LPD_EXT_RST_NS   30000
// ==========================================================
// Period measurement
`define LPD_SETTLE_CYC   8'h40
`define LPD_PERIODS      5'h10
`define LPD_CNT_MIN      16'h0640
`define LPD_CNT_MAX      16'h3e80
`define LPD_THR_NUM      40'h80
`define LPD_THR_DEN      40'h2710
`define LPD_FAIL_SHIFT   2
// ==========================================================
// Millisecond timings
`define LPD_MIN_MS       7'h64
`define LPD_PULSE_MS     7'h7d
`define LPD_TUNE_MS      11'h7d0
`define LPD_LAMP_PER_MS  10'h3e8
`define LPD_HALF_MS      10'h1f4
`define LPD_FLASH_MS     10'h032
`define LPD_FLASH_GAP_MS 10'h064
`define LPD_GREEN_MS     10'h2ee
// ==========================================================
// Switch reset values: enabled, fail-safe, presence, level 6
`define LPD_CHSW_RST     6'h1e
`define LPD_BOARD_RST    2'h0
`endif

// ### verilog/lpd_pkg.sv
// Types shared by the loop detector channel logic.
// Assumes lpd_params.svh supplies the numeric constants.
`default_nettype none
package lpd_pkg;
    // ==========================================================
    // Switch groups
    typedef struct packed {
        logic       dis;
        logic       fail_safe;
        logic       hold_while_occupied_setting;
        logic [2:0] sens;
    } lpd_chsw_t;

    typedef struct packed {
        logic test;
        logic min_out;
    } lpd_board_t;

    // ==========================================================
    // Fault kinds and scan states
    typedef enum logic [1:0] {
        lpd_fail_none  = 2'h0,
        lpd_fail_open  = 2'h1,
        lpd_fail_short = 2'h2
    } lpd_fail_t;

    typedef enum logic [1:0] {
        lpd_sc_settle = 2'h0,
        lpd_sc_arm    = 2'h1,
        lpd_sc_count  = 2'h3,
        lpd_sc_done   = 2'h2
    } lpd_scan_t;
endpackage : lpd_pkg
`default_nettype wire

// ### verilog/lpd_top.sv
// Two-channel inductive loop detector channel logic.
// Assumes squared loop inputs and switches synchronous to i_clk.
// Function
// - Minimum option off: call follows zone occupancy only.
// - Minimum option on: every call lasts at least 100 ms.
// - Minimum option applies only in presence operation.
// - Lamp dark with no detection, loop fine, no earlier failure.
// - Open loop or inductance rise over 25 percent: steady red.
// - Shorted loop or inductance drop over 25 percent: red at 1 Hz.
// - Healed loop: three 50 ms red flashes every second.
// - Detection without earlier failure: steady green.
// - Detection with earlier failure: three red flashes then 750 ms green.
// - Earlier failure cleared by external, channel or power reset.
// - Last failure indication kept until reset or power loss.
// - Any channel switch change except frequency resets the channel.
// - Reset contact held low 30 us resets both channels at once; the logic resets them at the first low sample.
// - Count clock cycles over several loop periods; keep reference count.
// - Call when percentage drop exceeds the sensitivity threshold.
// - Track slow drift in the reference without detecting.
// - Out of range or rapid 25 percent change enters failure mode.
// - Failure: fail-safe calls continuously, fail-secure gives no call.
// - Loops scanned alternately, one oscillator on at a time.
// - Switches strobed into the logic; frequency switches not read.
// - One independent call output per channel.
// - Board switch one selects self-test; defaults off.
// - Channel switch four on selects fail-safe, off fail-secure.
// - Pulse operation: one 125 ms pulse, tune out after two seconds.
// - Three sensitivity bits, threshold 1.28 percent halving to 0.01.
// - Channel switch one disables channel and hides its failure.
`default_nettype none
`include "lpd_params.svh"
module lpd_top #(
    parameter int P_TICK_CYC    = `LPD_TICK_CYC,
    parameter int P_TIMEOUT_CYC = `LPD_TIMEOUT_CYC
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic [1:0]               i_loop_sq,
    input  wire lpd_pkg::lpd_chsw_t [1:0] i_ch_sw,
    input  wire lpd_pkg::lpd_board_t      i_board_sw,
    input  wire logic                     i_ext_reset_n,
    output var  logic [1:0]               o_call,
    output var  logic [1:0]               o_osc_en,
    output var  logic                     o_sw_strobe,
    output wire logic [1:0]               o_lamp_red,
    output wire logic [1:0]               o_lamp_green,
    output var  logic                     o_test_mode
);
    import lpd_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic lpd_over(input logic [15:0] d, input logic [15:0] r, input logic [2:0] lvl);
        logic [39:0] a;
        logic [39:0] b;
        a = ({24'h0, d} * `LPD_THR_DEN) << lvl;
        b = {24'h0, r} * `LPD_THR_NUM;
        return a > b;
    endfunction : lpd_over

    function automatic logic lpd_rapid(input logic [15:0] m, input logic [15:0] r);
        logic [17:0] d;
        d = (m > r) ? {2'h0, m - r} : {2'h0, r - m};
        return (d << `LPD_FAIL_SHIFT) > {2'h0, r};
    endfunction : lpd_rapid

    // ==========================================================
    // Declarations
    logic [15:0]  tick_cnt_r;
    logic         tick_r;
    logic [9:0]   phase_r;
    lpd_chsw_t    sw_r [2];
    lpd_board_t   bd_r;
    logic         sw_ok_r;
    logic [1:0]   sw_chg_r;
    logic         ext_rst;
    logic [1:0]   ch_rst;
    lpd_scan_t    sc_r;
    logic         ch_r;
    logic [7:0]   settle_r;
    logic [15:0]  tmo_r;
    logic [15:0]  cyc_r;
    logic [4:0]   edges_r;
    logic [1:0]   sq_q_r;
    logic         rise;
    logic [15:0]  meas_r;
    logic         meas_open_r;
    logic [15:0]  ref_r [2];
    logic [1:0]   ref_ok_r;
    logic [1:0]   det_r;
    logic [1:0]   det_q_r;
    lpd_fail_t    fail_r [2];
    logic [1:0]   prior_r;
    logic [6:0]   min_r [2];
    logic [6:0]   pulse_r [2];
    logic [10:0]  occ_r [2];
    logic [1:0]   call_nxt;
    lpd_fail_t    lamp_fail [2];

    // ==========================================================
    // Common ms tick and 1 s lamp phase
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt_r <= 16'h0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == 16'(P_TICK_CYC - 1)) begin
            tick_cnt_r <= 16'h0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h1;
            tick_r     <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_r <= 10'h0;
        end else if (tick_r) begin
            phase_r <= (phase_r == `LPD_LAMP_PER_MS - 10'h1) ? 10'h0 : phase_r + 10'h1;
        end
    end

    // ==========================================================
    // Switch strobe and change detect
    // Strobe goes out the cycle after the tick; the switches are read one cycle later.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sw_strobe <= 1'b0;
            sw_r[0]     <= `LPD_CHSW_RST;
            sw_r[1]     <= `LPD_CHSW_RST;
            bd_r        <= `LPD_BOARD_RST;
            sw_ok_r     <= 1'b0;
            sw_chg_r    <= 2'h0;
            o_test_mode <= 1'b0;
        end else begin
            o_sw_strobe <= tick_r;
            sw_chg_r    <= 2'h0;
            if (o_sw_strobe) begin
                sw_r[0]     <= i_ch_sw[0];
                sw_r[1]     <= i_ch_sw[1];
                bd_r        <= i_board_sw;
                sw_ok_r     <= 1'b1;
                o_test_mode <= i_board_sw.test;
                // First read after power-up only loads, it is no change
                sw_chg_r[0] <= sw_ok_r && (i_ch_sw[0] != sw_r[0]);
                sw_chg_r[1] <= sw_ok_r && (i_ch_sw[1] != sw_r[1]);
            end
        end
    end

    // Contact is acted on at the first low sample, not after 30 us
    assign ext_rst = ~i_ext_reset_n;
    assign ch_rst  = sw_chg_r | {2{ext_rst}};

    // ==========================================================
    // Alternating scan and period counter
    assign rise = i_loop_sq[ch_r] & ~sq_q_r[ch_r];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sq_q_r <= 2'h0;
        end else begin
            sq_q_r <= i_loop_sq;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sc_r        <= lpd_sc_settle;
            ch_r        <= 1'b0;
            settle_r    <= 8'h0;
            tmo_r       <= 16'h0;
            cyc_r       <= 16'h0;
            edges_r     <= 5'h0;
            meas_r      <= 16'h0;
            meas_open_r <= 1'b0;
            o_osc_en    <= 2'h0;
        end else begin
            case (sc_r)
                lpd_sc_settle: begin
                    o_osc_en       <= 2'h0;
                    o_osc_en[ch_r] <= ~sw_r[ch_r].dis;
                    tmo_r          <= 16'h0;
                    if (settle_r == `LPD_SETTLE_CYC) begin
                        settle_r <= 8'h0;
                        sc_r     <= lpd_sc_arm;
                    end else begin
                        settle_r <= settle_r + 8'h1;
                    end
                end
                lpd_sc_arm: begin
                    tmo_r   <= tmo_r + 16'h1;
                    cyc_r   <= 16'h0;
                    edges_r <= 5'h0;
                    if (tmo_r == 16'(P_TIMEOUT_CYC - 1)) begin
                        meas_open_r <= 1'b1;
                        sc_r        <= lpd_sc_done;
                    end else if (rise) begin
                        sc_r <= lpd_sc_count;
                    end
                end
                lpd_sc_count: begin
                    tmo_r <= tmo_r + 16'h1;
                    cyc_r <= cyc_r + 16'h1;
                    if (tmo_r == 16'(P_TIMEOUT_CYC - 1)) begin
                        meas_open_r <= 1'b1;
                        sc_r        <= lpd_sc_done;
                    end else if (rise) begin
                        edges_r <= edges_r + 5'h1;
                        if (edges_r == `LPD_PERIODS - 5'h1) begin
                            meas_r      <= cyc_r + 16'h1;
                            meas_open_r <= 1'b0;
                            sc_r        <= lpd_sc_done;
                        end
                    end
                end
                lpd_sc_done: begin
                    // Oscillator off before the other one starts
                    o_osc_en <= 2'h0;
                    ch_r     <= ~ch_r;
                    sc_r     <= lpd_sc_settle;
                end
                default: begin
                    sc_r <= lpd_sc_settle;
                end
            endcase
        end
    end

    // ==========================================================
    // Reference, detection and fault classification
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int c = 0; c < 2; c++) begin
                ref_r[c]  <= 16'h0;
                fail_r[c] <= lpd_fail_none;
            end
            ref_ok_r <= 2'h0;
            det_r    <= 2'h0;
            prior_r  <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (ch_rst[c]) begin
                    ref_ok_r[c] <= 1'b0;
                    det_r[c]    <= 1'b0;
                    fail_r[c]   <= lpd_fail_none;
                    prior_r[c]  <= 1'b0;
                end else if (sw_r[c].dis) begin
                    ref_ok_r[c] <= 1'b0;
                    det_r[c]    <= 1'b0;
                    fail_r[c]   <= lpd_fail_none;
                end else if (sc_r == lpd_sc_done && ch_r == c[0]) begin
                    if (meas_open_r || meas_r > `LPD_CNT_MAX) begin
                        fail_r[c]  <= lpd_fail_open;
                        det_r[c]   <= 1'b0;
                        prior_r[c] <= 1'b1;
                    end else if (meas_r < `LPD_CNT_MIN) begin
                        fail_r[c]  <= lpd_fail_short;
                        det_r[c]   <= 1'b0;
                        prior_r[c] <= 1'b1;
                    end else if (ref_ok_r[c] && lpd_rapid(meas_r, ref_r[c])) begin
                        // Longer period means more inductance, shown like an open loop
                        fail_r[c]  <= (meas_r > ref_r[c]) ? lpd_fail_open : lpd_fail_short;
                        det_r[c]   <= 1'b0;
                        prior_r[c] <= 1'b1;
                    end else begin
                        fail_r[c] <= lpd_fail_none;
                        if (!ref_ok_r[c] || (!sw_r[c].hold_while_occupied_setting
                                             && occ_r[c] == `LPD_TUNE_MS)) begin
                            ref_r[c]    <= meas_r;
                            ref_ok_r[c] <= 1'b1;
                            det_r[c]    <= 1'b0;
                        end else if (meas_r < ref_r[c]) begin
                            det_r[c] <= lpd_over(ref_r[c] - meas_r, ref_r[c], sw_r[c].sens);
                            if (!lpd_over(ref_r[c] - meas_r, ref_r[c], sw_r[c].sens)) begin
                                // One count per scan is slow enough that no vehicle is lost
                                ref_r[c] <= ref_r[c] - 16'h1;
                            end
                        end else begin
                            det_r[c] <= 1'b0;
                            ref_r[c] <= meas_r;
                        end
                    end
                end
            end
        end
    end

    // ==========================================================
    // Call timers in ms ticks
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int c = 0; c < 2; c++) begin
                min_r[c]   <= 7'h0;
                pulse_r[c] <= 7'h0;
                occ_r[c]   <= 11'h0;
            end
            det_q_r <= 2'h0;
        end else begin
            det_q_r <= det_r;
            for (int c = 0; c < 2; c++) begin
                if (ch_rst[c]) begin
                    min_r[c]   <= 7'h0;
                    pulse_r[c] <= 7'h0;
                    occ_r[c]   <= 11'h0;
                end else begin
                    if (det_r[c] && !det_q_r[c]) begin
                        min_r[c]   <= `LPD_MIN_MS;
                        pulse_r[c] <= `LPD_PULSE_MS;
                    end else if (tick_r) begin
                        if (min_r[c] != 7'h0) begin
                            min_r[c] <= min_r[c] - 7'h1;
                        end
                        if (pulse_r[c] != 7'h0) begin
                            pulse_r[c] <= pulse_r[c] - 7'h1;
                        end
                    end
                    if (!det_r[c]) begin
                        occ_r[c] <= 11'h0;
                    end else if (tick_r && occ_r[c] != `LPD_TUNE_MS) begin
                        occ_r[c] <= occ_r[c] + 11'h1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Call outputs, one line per channel
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            if (sw_r[c].dis) begin
                call_nxt[c] = 1'b0;
            end else if (fail_r[c] != lpd_fail_none) begin
                call_nxt[c] = sw_r[c].fail_safe;
            end else if (sw_r[c].hold_while_occupied_setting) begin
                if (bd_r.min_out) begin
                    call_nxt[c] = det_r[c] || (min_r[c] != 7'h0);
                end else begin
                    call_nxt[c] = det_r[c];
                end
            end else begin
                // single_shot_output_setting
                call_nxt[c] = (pulse_r[c] != 7'h0);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_call <= 2'h0;
        end else begin
            o_call <= call_nxt & ~ch_rst;
        end
    end

    // ==========================================================
    // Status lamps
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lamp
            assign lamp_fail[g] = fail_r[g];
            lpd_lamp u_lamp (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_phase (phase_r),
                .i_det   (o_call[g] & (fail_r[g] == lpd_fail_none)),
                .i_fail  (lamp_fail[g]),
                .i_prior (prior_r[g] & ~sw_r[g].dis),
                .i_test  (o_test_mode),
                .o_red   (o_lamp_red[g]),
                .o_green (o_lamp_green[g])
            );
        end
    endgenerate
endmodule : lpd_top
`default_nettype wire
